// ===== logic/ybss_pkg.sv
package ybss_pkg;
  localparam int NCH = 4;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEC_CYC = CLK_HZ;
  localparam int FLASH_HZ = 2;
  localparam int FLASH_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam logic [6:0] DELAY_MAX = 7'h63;
  localparam logic [15:0] RUN_RPM = 16'h00AA;
  localparam logic [15:0] STOP_RPM = 16'h008C;
  localparam int KEY_SEQ_LEN = 5;
  localparam logic [3:0] KEY_SEQ0 = 4'h3;
  localparam logic [3:0] KEY_SEQ1 = 4'h1;
  localparam logic [3:0] KEY_SEQ2 = 4'h4;
  localparam logic [3:0] KEY_SEQ3 = 4'h2;
  localparam logic [3:0] KEY_SEQ4 = 4'h5;
  localparam logic [3:0] KEY_TEST = 4'h3;
  localparam logic [3:0] KEY_SETTINGS = 4'h1;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_CHAN = 8'h10;
  localparam logic [7:0] REG_SPEED = 8'h14;
  localparam logic [7:0] REG_KEY = 8'h18;
  // ctrl fields
  localparam int CTRL_DELAY_LSB = 0;
  localparam int CTRL_RUNSRC_BIT = 8;
  localparam int CTRL_LAMP_BIT = 9;
  localparam int CTRL_LASER_BIT = 10;
  localparam int CTRL_FAULT_BIT = 11;
  localparam int CTRL_MODFLT_BIT = 12;
  localparam int CTRL_SELFTEST_BIT = 13;
  localparam int CTRL_STOPCLR_BIT = 14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // irq bits
  localparam int IRQ_BREAK = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_UNLOCK = 3;
  localparam int NIRQ = 4;
  typedef enum logic [1:0] {
    YBSS_OFF = 2'h0, YBSS_GREEN = 2'h1, YBSS_YELLOW = 2'h2, YBSS_RED = 2'h3
  } ybss_color_t;
endpackage : ybss_pkg

// ===== logic/ybss_run_detect.sv
`timescale 1ns/10ps
module ybss_run_detect (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sources
  input wire logic run_sel_internal,
  input wire logic run_in_sync,
  input wire logic [15:0] speed_rpm,
  // result
  output logic running
);
  import ybss_pkg::*;
  logic spd_run;
  logic next_spd_run;

  always_comb begin
    next_spd_run = spd_run;
    if (speed_rpm > RUN_RPM) begin
      next_spd_run = 1'b1;
    end else if (speed_rpm < STOP_RPM) begin
      next_spd_run = 1'b0;
    end
    // between thresholds the old decision holds
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_run <= 1'b0;
    end else begin
      spd_run <= next_spd_run;
    end
  end

  // external level high while machine runs, low when stopped or inching
  assign running = run_sel_internal ? spd_run : run_in_sync;

  hyst_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (speed_rpm >= STOP_RPM && speed_rpm <= RUN_RPM) |=> spd_run == $past(spd_run))
    else $error("speed hysteresis not held");
  run_above_a: assert property (@(posedge pclk) disable iff (!presetn)
    (speed_rpm > RUN_RPM) |=> spd_run)
    else $error("run not declared above threshold");
  stop_below_a: assert property (@(posedge pclk) disable iff (!presetn)
    (speed_rpm < STOP_RPM) |=> !spd_run)
    else $error("stop not declared below threshold");
endmodule : ybss_run_detect

// ===== logic/ybss_supervisor.sv
`timescale 1ns/10ps
// How it works
// - A common start delay of 0 to 99 whole seconds is held, zero meaning no delay.
// - After the machine starts every channel ignores breaks until the delay has run out.
// - Run source selects external input (default) or internal speed.
// - Internal source declares running once speed is above 170 rpm.
// - Internal source declares stopped once speed is below 140 rpm.
// - Lamp style one lights steadily when stopped not by the monitor and not in test mode.
// - Lamp style one flashes after a monitor stop or in test mode, dark while running.
// - Lamp style two lights only after a monitor stop.
// - With auto switch-off, lasers are off while stopped unless in test mode.
// - Auto switch-off acts on every connected and activated channel and is toggled.
// - System indicator: green, flashing green running, flashing yellow delay, red stop, flashing red fault.
// - Status indicator: green, yellow in self-test, flashing yellow on module fault.
// - Each test key press toggles test mode, except one made inside a settings key sequence.
// - Settings unlock only after the settings key 1 followed by keys 3,1,4,2,5 in order.
// - An active channel above its threshold in normal operation registers a break and stops the machine.
module ybss_supervisor (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // machine side
  input wire logic run_in,
  output logic stop_out,
  output logic lamp_out,
  // channels
  input wire logic [ybss_pkg::NCH-1:0] chan_connected,
  input wire logic [ybss_pkg::NCH-1:0] chan_over_level,
  output logic [ybss_pkg::NCH-1:0] laser_on,
  // keypad
  input wire logic key_valid,
  input wire logic [3:0] key_code,
  // indicators and interrupt
  output ybss_pkg::ybss_color_t sys_led,
  output logic sys_led_flash,
  output ybss_pkg::ybss_color_t stat_led,
  output logic stat_led_flash,
  output logic irq
);
  import ybss_pkg::*;

  logic run_m;
  logic run_s;
  logic running;
  logic run_d;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [NCH-1:0] chan_act;
  logic [NCH-1:0] next_chan_act;
  logic [15:0] speed;
  logic [15:0] next_speed;
  logic [NIRQ-1:0] irq_stat;
  logic [NIRQ-1:0] next_irq_stat;
  logic [NIRQ-1:0] irq_mask;
  logic [NIRQ-1:0] next_irq_mask;
  logic test_mode;
  logic next_test_mode;
  logic unlocked;
  logic next_unlocked;
  logic [2:0] key_pos;
  logic [2:0] next_key_pos;
  logic mon_stop;
  logic next_mon_stop;
  logic [NCH-1:0] brk_chan;
  logic [NCH-1:0] next_brk_chan;
  logic [26:0] sec_cnt;
  logic [26:0] next_sec_cnt;
  logic [6:0] delay_left;
  logic [6:0] next_delay_left;
  logic [24:0] fl_cnt;
  logic [24:0] next_fl_cnt;
  logic flash;
  logic next_flash;
  logic wr;
  logic rd;
  logic addr_ok;
  logic delay_active;
  logic [NCH-1:0] brk_now;
  logic [NIRQ-1:0] ev;
  logic [31:0] next_prdata;

  function automatic logic [3:0] seq_key(input logic [2:0] pos);
    unique case (pos)
      3'h0: seq_key = KEY_SEQ0;
      3'h1: seq_key = KEY_SEQ1;
      3'h2: seq_key = KEY_SEQ2;
      3'h3: seq_key = KEY_SEQ3;
      default: seq_key = KEY_SEQ4;
    endcase
  endfunction : seq_key

  // pin input crosses in via two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_m <= 1'b0;
      run_s <= 1'b0;
    end else begin
      run_m <= run_in;
      run_s <= run_m;
    end
  end

  ybss_run_detect u_run (
    .pclk(pclk),
    .presetn(presetn),
    .run_sel_internal(ctrl[CTRL_RUNSRC_BIT]),
    .run_in_sync(run_s),
    .speed_rpm(speed),
    .running(running)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign addr_ok = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_IRQ_STAT
    || paddr == REG_IRQ_MASK || paddr == REG_CHAN || paddr == REG_SPEED || paddr == REG_KEY;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign delay_active = delay_left != 7'h00;

  // channels only trip when active, running, past the delay, not in test
  // run_d keeps the first running cycle out, before the delay has been loaded
  assign brk_now = (running && run_d && !delay_active && !test_mode) ?
    (chan_over_level & chan_act & chan_connected) : '0;
  assign ev[IRQ_BREAK] = |brk_now && !mon_stop;
  assign ev[IRQ_START] = running && !run_d;
  assign ev[IRQ_STOP] = !running && run_d;
  assign ev[IRQ_UNLOCK] = next_unlocked && !unlocked;

  always_comb begin
    next_ctrl = ctrl;
    next_chan_act = chan_act;
    next_speed = speed;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_prdata = prdata;
    if (wr && paddr == REG_CTRL) begin
      next_ctrl = pwdata;
      if (pwdata[CTRL_DELAY_LSB +: 7] > DELAY_MAX) begin
        next_ctrl[CTRL_DELAY_LSB +: 7] = DELAY_MAX;
      end
      next_ctrl[CTRL_STOPCLR_BIT] = 1'b0;
    end
    if (wr && paddr == REG_CHAN) begin
      next_chan_act = pwdata[NCH-1:0];
    end
    if (wr && paddr == REG_SPEED) begin
      next_speed = pwdata[15:0];
    end
    if (wr && paddr == REG_IRQ_MASK) begin
      next_irq_mask = pwdata[NIRQ-1:0];
    end
    if (wr && paddr == REG_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata[NIRQ-1:0];
    end
    next_irq_stat = next_irq_stat | ev; // set wins over clear
    if (rd) begin
      unique case (paddr)
        REG_CTRL: next_prdata = ctrl;
        REG_STATUS: next_prdata = {16'h0000, brk_chan, 1'b0, delay_left,
          unlocked, test_mode, mon_stop, running};
        REG_IRQ_STAT: next_prdata = {{(32-NIRQ){1'b0}}, irq_stat};
        REG_IRQ_MASK: next_prdata = {{(32-NIRQ){1'b0}}, irq_mask};
        REG_CHAN: next_prdata = {{(32-NCH){1'b0}}, chan_act};
        REG_SPEED: next_prdata = {16'h0000, speed};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_test_mode = test_mode;
    next_unlocked = unlocked;
    next_key_pos = key_pos;
    if (key_valid) begin
      if (key_code == KEY_TEST && key_pos == 3'h0) begin
        next_test_mode = !test_mode;
      end
      if (key_pos == 3'h0) begin
        if (key_code == KEY_SETTINGS) begin
          next_key_pos = 3'h1;
        end
      end else if (key_code == seq_key(3'(key_pos - 3'h1))) begin
        if (key_pos == 3'(KEY_SEQ_LEN)) begin
          next_unlocked = 1'b1;
          next_key_pos = 3'h0;
        end else begin
          next_key_pos = key_pos + 3'h1;
        end
      end else begin
        next_key_pos = 3'h0; // wrong key, stays locked
      end
    end
    if (wr && paddr == REG_KEY) begin
      next_unlocked = 1'b0;
    end
  end

  always_comb begin
    next_mon_stop = mon_stop;
    next_brk_chan = brk_chan;
    if (|brk_now) begin
      next_mon_stop = 1'b1;
      next_brk_chan = brk_chan | brk_now;
    end else if (wr && paddr == REG_CTRL && pwdata[CTRL_STOPCLR_BIT]) begin
      next_mon_stop = 1'b0;
      next_brk_chan = '0;
    end
    next_sec_cnt = sec_cnt;
    next_delay_left = delay_left;
    if (running && !run_d) begin
      next_delay_left = ctrl[CTRL_DELAY_LSB +: 7];
      next_sec_cnt = 27'(SEC_CYC - 1);
    end else if (!running) begin
      next_delay_left = 7'h00;
    end else if (delay_active) begin
      if (sec_cnt == 27'h0) begin
        next_sec_cnt = 27'(SEC_CYC - 1);
        next_delay_left = delay_left - 7'h01;
      end else begin
        next_sec_cnt = sec_cnt - 27'h1;
      end
    end
    next_fl_cnt = fl_cnt - 25'h1;
    next_flash = flash;
    if (fl_cnt == 25'h0) begin
      next_fl_cnt = 25'(FLASH_CYC - 1);
      next_flash = !flash;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET; // external run source by default
      chan_act <= '0;
      speed <= 16'h0000;
      irq_mask <= '0;
      irq_stat <= '0;
      prdata <= 32'h0000_0000;
      test_mode <= 1'b0;
      unlocked <= 1'b0;
      key_pos <= 3'h0;
      mon_stop <= 1'b0;
      brk_chan <= '0;
      sec_cnt <= 27'h0;
      delay_left <= 7'h00;
      fl_cnt <= 25'h0;
      flash <= 1'b0;
      run_d <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      chan_act <= next_chan_act;
      speed <= next_speed;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      prdata <= next_prdata;
      test_mode <= next_test_mode;
      unlocked <= next_unlocked;
      key_pos <= next_key_pos;
      mon_stop <= next_mon_stop;
      brk_chan <= next_brk_chan;
      sec_cnt <= next_sec_cnt;
      delay_left <= next_delay_left;
      fl_cnt <= next_fl_cnt;
      flash <= next_flash;
      run_d <= running;
    end
  end

  assign irq = |(irq_stat & irq_mask);
  assign stop_out = mon_stop;

  always_comb begin
    if (ctrl[CTRL_LAMP_BIT]) begin
      lamp_out = mon_stop;
    end else if (mon_stop || test_mode) begin
      lamp_out = flash;
    end else begin
      lamp_out = !running;
    end
  end

  // switch-off covers every connected, activated channel
  assign laser_on = (ctrl[CTRL_LASER_BIT] && !running && !test_mode) ? '0 :
    (chan_act & chan_connected);

  always_comb begin
    sys_led = YBSS_GREEN;
    sys_led_flash = 1'b0;
    if (ctrl[CTRL_FAULT_BIT]) begin
      sys_led = YBSS_RED;
      sys_led_flash = 1'b1;
    end else if (mon_stop) begin
      sys_led = YBSS_RED;
    end else if (running && delay_active) begin
      sys_led = YBSS_YELLOW;
      sys_led_flash = 1'b1;
    end else if (running) begin
      sys_led_flash = 1'b1;
    end
    stat_led = YBSS_GREEN;
    stat_led_flash = 1'b0;
    if (ctrl[CTRL_MODFLT_BIT]) begin
      stat_led = YBSS_YELLOW;
      stat_led_flash = 1'b1;
    end else if (ctrl[CTRL_SELFTEST_BIT]) begin
      stat_led = YBSS_YELLOW;
    end
  end

  laser_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[CTRL_LASER_BIT] && !running && !test_mode) |-> laser_on == '0)
    else $error("laser on while stopped");
  no_trip_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (delay_active || test_mode) && !mon_stop |=> !mon_stop)
    else $error("break taken during delay or test");
  trip_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    |brk_now |=> mon_stop && stop_out)
    else $error("break did not stop machine");
  test_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    key_valid && key_code == KEY_TEST && key_pos == 3'h0 |=> test_mode != $past(test_mode))
    else $error("test key did not toggle");
  lamp_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CTRL_LAMP_BIT] |-> lamp_out == mon_stop)
    else $error("lamp style two wrong");
  lamp_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[CTRL_LAMP_BIT] && running && !mon_stop && !test_mode |-> !lamp_out)
    else $error("lamp lit while running");
  lamp_steady_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[CTRL_LAMP_BIT] && !running && !mon_stop && !test_mode |-> lamp_out)
    else $error("lamp dark while stopped");
  delay_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CTRL_DELAY_LSB +: 7] <= DELAY_MAX)
    else $error("start delay above limit");
  unlock_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
    !unlocked ##1 unlocked |-> $past(key_valid) && $past(key_pos) == 3'(KEY_SEQ_LEN))
    else $error("unlocked without full sequence");
  sys_red_a: assert property (@(posedge pclk) disable iff (!presetn)
    mon_stop && !ctrl[CTRL_FAULT_BIT] |-> sys_led == YBSS_RED && !sys_led_flash)
    else $error("system led not red after stop");
  stat_flt_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CTRL_MODFLT_BIT] |-> stat_led == YBSS_YELLOW && stat_led_flash)
    else $error("status led not flashing on fault");
endmodule : ybss_supervisor

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import ybss_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, key_valid = 1'b0, want_run = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, run_in, stop_out, lamp_out, sys_led_flash, stat_led_flash, irq, err;
  logic [NCH-1:0] chan_connected = 4'hF, chan_over_level = 4'h0, laser_on;
  logic [3:0] key_code = 4'h0;
  ybss_color_t sys_led, stat_led;
  int n_errors = 0, comparisons = 0;
  always #5 pclk = ~pclk;
  ybss_supervisor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_in(run_in), .stop_out(stop_out), .lamp_out(lamp_out),
    .chan_connected(chan_connected), .chan_over_level(chan_over_level), .laser_on(laser_on),
    .key_valid(key_valid), .key_code(key_code), .sys_led(sys_led),
    .sys_led_flash(sys_led_flash), .stat_led(stat_led), .stat_led_flash(stat_led_flash),
    .irq(irq));
  ybss_machine_model i_machine (.pclk(pclk), .presetn(presetn), .want_run(want_run),
    .stop_out(stop_out), .run_in(run_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  // starts on a fresh edge so back-to-back calls never touch psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic key(input logic [3:0] c);
    @(posedge pclk);
    key_valid <= 1'b1;
    key_code <= c;
    @(posedge pclk);
    key_valid <= 1'b0;
  endtask : key
  task automatic keys(input logic [23:0] s);
    for (int i = 5; i >= 0; i--) begin
      key(s[i*4+:4]);
    end
    tick(2);
  endtask : keys
  task automatic done(input string name);
    $display("test %s finished, errors so far %0d", name, n_errors);
  endtask : done
  task automatic t_reset;
    chk(stop_out, 1'b0);
    chk(lamp_out, 1'b1);
    chk({sys_led, sys_led_flash, stat_led, stat_led_flash, irq}, {YBSS_GREEN, 1'b0, YBSS_GREEN, 2'h0});
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    done("reset");
  endtask : t_reset
  task automatic t_break;
    apb(1'b1, REG_CHAN, 32'h1);
    want_run <= 1'b1;
    tick(6);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    chk({lamp_out, sys_led, sys_led_flash}, {1'b0, YBSS_GREEN, 1'b1});
    chk(irq, 1'b0);
    apb(1'b1, REG_IRQ_MASK, 32'hF);
    tick(1);
    chk(irq, 1'b1);
    apb(1'b1, REG_IRQ_STAT, 32'hF);
    tick(1);
    chk(irq, 1'b0);
    chan_over_level <= 4'h1;
    tick(2);
    chan_over_level <= 4'h0;
    chk({stop_out, sys_led, sys_led_flash}, {1'b1, YBSS_RED, 1'b0});
    tick(6);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[1:0], 2'h2);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, REG_CTRL, 32'h200);
    tick(1);
    chk(lamp_out, 1'b1);
    want_run <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h4200);
    tick(2);
    chk({stop_out, lamp_out}, 2'h0);
    apb(1'b1, REG_CTRL, 32'h0);
    tick(1);
    chk(lamp_out, 1'b1);
    done("break");
  endtask : t_break
  task automatic t_laser;
    apb(1'b1, REG_CHAN, 32'h3);
    apb(1'b1, REG_CTRL, 32'h400);
    tick(1);
    chk(laser_on, 4'h0);
    key(KEY_TEST);
    tick(2);
    chk(laser_on, 4'h3);
    want_run <= 1'b1;
    tick(6);
    chan_over_level <= 4'h1;
    tick(3);
    chan_over_level <= 4'h0;
    chk(stop_out, 1'b0);
    key(KEY_TEST);
    tick(2);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2], 1'b0);
    chan_connected <= 4'h1;
    tick(1);
    chk(laser_on, 4'h1);
    want_run <= 1'b0;
    tick(6);
    chk(laser_on, 4'h0);
    chan_connected <= 4'hF;
    apb(1'b1, REG_CTRL, 32'h0);
    tick(1);
    chk(laser_on, 4'h3);
    done("laser");
  endtask : t_laser
  task automatic t_speed;
    logic [15:0] spd [8] = '{16'd171, 16'd150, 16'd140, 16'd139, 16'd150, 16'd170, 16'd171, 16'd0};
    logic [7:0] run_exp = 8'b1110_0010;
    apb(1'b1, REG_CTRL, 32'h100);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, REG_SPEED, {16'h0, spd[i]});
      tick(3);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[0], run_exp[7-i]);
    end
    apb(1'b1, REG_CTRL, 32'h0);
    done("speed");
  endtask : t_speed
  task automatic t_delay;
    apb(1'b1, REG_CTRL, 32'h77);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd[6:0], DELAY_MAX);
    apb(1'b1, REG_CTRL, 32'h1);
    // threshold already exceeded as the machine starts: the start cycle must not trip
    chan_over_level <= 4'h1;
    want_run <= 1'b1;
    tick(6);
    chk({sys_led, sys_led_flash}, {YBSS_YELLOW, 1'b1});
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[10:4], 7'h1);
    chk(rd[1], 1'b0);
    tick(3);
    chan_over_level <= 4'h0;
    chk(stop_out, 1'b0);
    want_run <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0);
    done("delay");
  endtask : t_delay
  task automatic t_keys;
    keys(24'h131425);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:2], 2'h2);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd[IRQ_UNLOCK], 1'b1);
    apb(1'b1, REG_KEY, 32'h0);
    keys(24'h131452);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[3:2], 2'h0);
    done("keys");
  endtask : t_keys
  task automatic t_faults;
    logic [31:0] cw [3] = '{32'h800, 32'h2000, 32'h1000};
    logic [5:0] ex [3] = '{{YBSS_RED, 1'b1, YBSS_GREEN, 1'b0},
      {YBSS_GREEN, 1'b0, YBSS_YELLOW, 1'b0}, {YBSS_GREEN, 1'b0, YBSS_YELLOW, 1'b1}};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, REG_CTRL, cw[i]);
      tick(1);
      chk({sys_led, sys_led_flash, stat_led, stat_led_flash}, ex[i]);
    end
    apb(1'b1, REG_CTRL, 32'h0);
    done("faults");
  endtask : t_faults
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    tick(6);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_break();
    t_laser();
    t_speed();
    t_delay();
    t_keys();
    t_faults();
    end_of_test();
  end
  // the whole sequence needs about 260 cycles
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule : testbench

// ===== testbench/ybss_machine_model.sv
`timescale 1ns/10ps
module ybss_machine_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // operator wish and stop circuit
  input wire logic want_run,
  input wire logic stop_out,
  // run level towards the monitor
  output logic run_in
);
  // an opened stop circuit halts the drive whatever the operator wants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_in <= 1'b0;
    end else begin
      run_in <= want_run & ~stop_out;
    end
  end
endmodule : ybss_machine_model
